// ---- rtl/mjc_manual_jog.sv ----
// Contract
// - 16-bit I/O mode register, resets to 0.
// - Pin jog accepted only in mode 2.
// - Anticlockwise jog input high moves anticlockwise.
// - Clockwise jog input high moves clockwise.
// - Stop input low forces quick stop.
// - Automatic input high selects automatic operation.
// - Enable input high enables power amplifier.
// - Speed select input picks fast or slow.
// - Software may force input logical states.
// - Jog speeds and current are configurable.
// - Limits bound clockwise and anticlockwise travel.
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "mjc_params.svh"

module mjc_manual_jog (
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire logic [3:0]          reg_addr,
    input  wire logic [15:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [15:0]         reg_rdata,
    input  wire logic                pin_positive_limit_switch,
    input  wire logic                pin_negative_limit_switch,
    input  wire logic                pin_stop,
    input  wire logic                pin_jog_clockwise,
    input  wire logic                pin_jog_anticlockwise,
    input  wire logic                pin_jog_speed_select,
    input  wire logic                pin_enable,
    input  wire logic                pin_automatic_mode_select,
    output mjc_pkg::mjc_dir_t        jog_dir,
    output logic                     jog_fast,
    output logic      [15:0]         jog_speed,
    output logic      [15:0]         jog_current,
    output logic                     quick_stop,
    output logic                     amp_enable,
    output logic                     auto_mode
);
    import mjc_pkg::*;

    // ****************************************************************
    // Input synchronisers.
    // ****************************************************************
    logic [`MJC_IN_W-1:0] pins_raw;
    logic [`MJC_IN_W-1:0] sync1_r;
    logic [`MJC_IN_W-1:0] sync2_r;

    assign pins_raw = {pin_automatic_mode_select, pin_enable, pin_jog_speed_select,
                       pin_jog_anticlockwise, pin_jog_clockwise, pin_stop,
                       pin_negative_limit_switch, pin_positive_limit_switch};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
        end
    end

    // ****************************************************************
    // Registers.
    // ****************************************************************
    logic [15:0] io_assignment_mode_r;
    logic [15:0] input_enable_mask_r;
    logic [15:0] input_polarity_mask_r;
    logic [15:0] force_ctrl_r;
    logic [15:0] force_val_r;
    logic [15:0] slow_speed_r;
    logic [15:0] fast_speed_r;
    logic [15:0] jog_current_r;
    logic [15:0] reg_rdata_r;

    wire wr_mode = reg_wr && (reg_addr == `MJC_OFS_IO_MODE);
    wire wr_en   = reg_wr && (reg_addr == `MJC_OFS_IN_ENABLE);
    wire wr_pol  = reg_wr && (reg_addr == `MJC_OFS_IN_POLARITY);
    wire wr_fc   = reg_wr && (reg_addr == `MJC_OFS_FORCE_CTRL);
    wire wr_fv   = reg_wr && (reg_addr == `MJC_OFS_FORCE_VAL);
    wire wr_slow = reg_wr && (reg_addr == `MJC_OFS_SLOW_SPEED);
    wire wr_fast = reg_wr && (reg_addr == `MJC_OFS_FAST_SPEED);
    wire wr_cur  = reg_wr && (reg_addr == `MJC_OFS_JOG_CURRENT);

    // Each word sits in its own small register, so a new setting costs one instance.
    mjc_cfg_reg #(
        .W   (16),
        .RST (`MJC_RST_IO_MODE)
    ) io_mode_reg_i (
        .clk    (clk),
        .arst_n (arst_n),
        .wr_en  (wr_mode),
        .wdata  (reg_wdata),
        .q      (io_assignment_mode_r)
    );

    mjc_cfg_reg #(
        .W   (16),
        .RST (`MJC_RST_IN_ENABLE)
    ) in_enable_reg_i (
        .clk    (clk),
        .arst_n (arst_n),
        .wr_en  (wr_en),
        .wdata  (reg_wdata),
        .q      (input_enable_mask_r)
    );

    mjc_cfg_reg #(
        .W   (16),
        .RST (`MJC_RST_IN_POLARITY)
    ) in_polarity_reg_i (
        .clk    (clk),
        .arst_n (arst_n),
        .wr_en  (wr_pol),
        .wdata  (reg_wdata),
        .q      (input_polarity_mask_r)
    );

    mjc_cfg_reg #(
        .W   (16),
        .RST (`MJC_RST_FORCE_CTRL)
    ) force_ctrl_reg_i (
        .clk    (clk),
        .arst_n (arst_n),
        .wr_en  (wr_fc),
        .wdata  (reg_wdata),
        .q      (force_ctrl_r)
    );

    mjc_cfg_reg #(
        .W   (16),
        .RST (`MJC_RST_FORCE_VAL)
    ) force_val_reg_i (
        .clk    (clk),
        .arst_n (arst_n),
        .wr_en  (wr_fv),
        .wdata  (reg_wdata),
        .q      (force_val_r)
    );

    mjc_cfg_reg #(
        .W   (16),
        .RST (`MJC_RST_SLOW_SPEED)
    ) slow_speed_reg_i (
        .clk    (clk),
        .arst_n (arst_n),
        .wr_en  (wr_slow),
        .wdata  (reg_wdata),
        .q      (slow_speed_r)
    );

    mjc_cfg_reg #(
        .W   (16),
        .RST (`MJC_RST_FAST_SPEED)
    ) fast_speed_reg_i (
        .clk    (clk),
        .arst_n (arst_n),
        .wr_en  (wr_fast),
        .wdata  (reg_wdata),
        .q      (fast_speed_r)
    );

    mjc_cfg_reg #(
        .W   (16),
        .RST (`MJC_RST_JOG_CURRENT)
    ) jog_current_reg_i (
        .clk    (clk),
        .arst_n (arst_n),
        .wr_en  (wr_cur),
        .wdata  (reg_wdata),
        .q      (jog_current_r)
    );

    // ****************************************************************
    // Logical input states.
    // ****************************************************************
    // Forcing acts on the logical state, so a forced bit ignores the pin level.
    logic [`MJC_IN_W-1:0] in_state;
    assign in_state = (sync2_r & ~force_ctrl_r[`MJC_IN_W-1:0])
                    | (force_val_r[`MJC_IN_W-1:0] & force_ctrl_r[`MJC_IN_W-1:0]);

    // Masked-off safety inputs read as inactive; polarity bit 1 means active high.
    wire positive_limit_switch_act = input_enable_mask_r[0] &
                    (in_state[`MJC_IN_POSITIVE_LIMIT_SWITCH] == input_polarity_mask_r[0]);
    wire negative_limit_switch_act = input_enable_mask_r[1] &
                    (in_state[`MJC_IN_NEGATIVE_LIMIT_SWITCH] == input_polarity_mask_r[1]);
    wire stop_act = input_enable_mask_r[2] &
                    (in_state[`MJC_IN_STOP] == input_polarity_mask_r[2]);

    wire fixed_mode = (io_assignment_mode_r == `MJC_MODE_FIXED);
    wire cw_req     = fixed_mode & in_state[`MJC_IN_JOG_CW];
    wire acw_req    = fixed_mode & in_state[`MJC_IN_JOG_ACW];
    wire auto_sel   = fixed_mode & in_state[`MJC_IN_AUTO];
    wire amp_on     = fixed_mode & in_state[`MJC_IN_ENABLE];
    wire fast_sel   = fixed_mode & in_state[`MJC_IN_FAST];

    // Jogging needs manual mode, an enabled amplifier and no quick stop.
    wire jog_ok  = amp_on & ~auto_sel & ~stop_act;
    wire move_cw  = jog_ok & cw_req & ~acw_req & ~positive_limit_switch_act;
    wire move_acw = jog_ok & acw_req & ~cw_req & ~negative_limit_switch_act;

    mjc_dir_t dir_nxt;
    assign dir_nxt = move_cw ? MJC_DIR_CW : (move_acw ? MJC_DIR_ACW : MJC_DIR_STOP);

    // ****************************************************************
    // Outputs and read port.
    // ****************************************************************
    logic [15:0] rd_mux;
    wire  [15:0] status_word = {9'h000, fixed_mode, auto_sel, amp_on, stop_act,
                                fast_sel, dir_nxt};

    always_comb begin
        case (reg_addr)
            `MJC_OFS_IO_MODE:     rd_mux = io_assignment_mode_r;
            `MJC_OFS_IN_ENABLE:   rd_mux = input_enable_mask_r;
            `MJC_OFS_IN_POLARITY: rd_mux = input_polarity_mask_r;
            `MJC_OFS_FORCE_CTRL:  rd_mux = force_ctrl_r;
            `MJC_OFS_FORCE_VAL:   rd_mux = force_val_r;
            `MJC_OFS_SLOW_SPEED:  rd_mux = slow_speed_r;
            `MJC_OFS_FAST_SPEED:  rd_mux = fast_speed_r;
            `MJC_OFS_JOG_CURRENT: rd_mux = jog_current_r;
            `MJC_OFS_IN_STATE:    rd_mux = {8'h00, in_state};
            `MJC_OFS_STATUS:      rd_mux = status_word;
            default:              rd_mux = 16'h0000;
        endcase
    end

    // ****************************************************************
    // Output flops.
    // ****************************************************************
    mjc_dir_t    dir_r;
    logic        fast_r;
    logic        qstop_r;
    logic        amp_r;
    logic        auto_r;
    logic [15:0] speed_r;

    // Direction and speed share one edge, so the drive never sees a mixed pair.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dir_r   <= MJC_DIR_STOP;
            fast_r  <= 1'b0;
            speed_r <= 16'h0000;
        end else begin
            dir_r   <= dir_nxt;
            fast_r  <= fast_sel;
            speed_r <= fast_sel ? fast_speed_r : slow_speed_r;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            qstop_r <= 1'b0;
            amp_r   <= 1'b0;
            auto_r  <= 1'b0;
        end else begin
            qstop_r <= stop_act;
            amp_r   <= amp_on;
            auto_r  <= auto_sel;
        end
    end

    // Read data are cleared outside a read, so a stale word never lingers.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_r <= 16'h0000;
        end else begin
            reg_rdata_r <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    assign jog_dir     = dir_r;
    assign jog_fast    = fast_r;
    assign jog_speed   = speed_r;
    assign jog_current = jog_current_r;
    assign quick_stop  = qstop_r;
    assign amp_enable  = amp_r;
    assign auto_mode   = auto_r;
    assign reg_rdata   = reg_rdata_r;

endmodule

// ****************************************************************
// One configuration word with its own write enable.
// ****************************************************************
module mjc_cfg_reg #(
    parameter int           W   = 16,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wdata,
    output logic      [W-1:0] q
);
    logic [W-1:0] q_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q_r <= RST;
        end else if (wr_en) begin
            q_r <= wdata;
        end
    end

    assign q = q_r;

endmodule

// ---- rtl/mjc_params.svh ----
`ifndef MJC_PARAMS_SVH
`define MJC_PARAMS_SVH

// ****************************************************************
// Register offsets.
// ****************************************************************
`define MJC_OFS_IO_MODE      4'h0
`define MJC_OFS_IN_ENABLE    4'h1
`define MJC_OFS_IN_POLARITY  4'h2
`define MJC_OFS_FORCE_CTRL   4'h3
`define MJC_OFS_FORCE_VAL    4'h4
`define MJC_OFS_SLOW_SPEED   4'h5
`define MJC_OFS_FAST_SPEED   4'h6
`define MJC_OFS_JOG_CURRENT  4'h7
`define MJC_OFS_IN_STATE     4'h8
`define MJC_OFS_STATUS       4'h9

// ****************************************************************
// Reset values.
// ****************************************************************
`define MJC_RST_IO_MODE      16'h0000
`define MJC_RST_IN_ENABLE    16'h0007
`define MJC_RST_IN_POLARITY  16'h0000
`define MJC_RST_SLOW_SPEED   16'h003c
`define MJC_RST_FAST_SPEED   16'h0258
`define MJC_RST_JOG_CURRENT  16'h0009
`define MJC_RST_FORCE_CTRL   16'h0000
`define MJC_RST_FORCE_VAL    16'h0000

// ****************************************************************
// I/O mode values.
// ****************************************************************
`define MJC_MODE_FIELDBUS    16'h0000
`define MJC_MODE_FREE        16'h0001
`define MJC_MODE_FIXED       16'h0002

// ****************************************************************
// Input vector bit positions.
// ****************************************************************
`define MJC_IN_POSITIVE_LIMIT_SWITCH          0
`define MJC_IN_NEGATIVE_LIMIT_SWITCH          1
`define MJC_IN_STOP          2
`define MJC_IN_JOG_CW        3
`define MJC_IN_JOG_ACW       4
`define MJC_IN_FAST          5
`define MJC_IN_ENABLE        6
`define MJC_IN_AUTO          7
`define MJC_IN_W             8

`endif

// ---- rtl/mjc_pkg.sv ----
package mjc_pkg;
    typedef enum logic [1:0] {
        MJC_DIR_STOP = 2'b00,
        MJC_DIR_CW   = 2'b01,
        MJC_DIR_ACW  = 2'b10
    } mjc_dir_t;
endpackage

// ---- verif/mjc_jog_properties.sv ----
`timescale 1ns/1ps
module mjc_jog_checker (
    input wire logic              clk,
    input wire logic              arst_n,
    input wire logic [3:0]        reg_addr,
    input wire logic [15:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              pin_positive_limit_switch,
    input wire logic              pin_negative_limit_switch,
    input wire logic              pin_stop,
    input wire logic              pin_jog_clockwise,
    input wire logic              pin_jog_anticlockwise,
    input wire logic              pin_jog_speed_select,
    input wire logic              pin_enable,
    input wire logic              pin_automatic_mode_select,
    input wire mjc_pkg::mjc_dir_t jog_dir,
    input wire logic              jog_fast,
    input wire logic              quick_stop,
    input wire logic              amp_enable,
    input wire logic              auto_mode
);
    import mjc_pkg::*;
    // The mode and the input set-up are mirrored from bus writes, as no register is visible here.
    logic [15:0] mode_r;
    logic [2:0]  dflt_r;
    logic [3:0]  ok_r;
    wire         calm = &ok_r;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_r <= 16'h0000;
            dflt_r <= 3'h7;
            ok_r   <= 4'h0;
        end else begin
            ok_r <= {ok_r[2:0], (&dflt_r) && mode_r == 16'h0002};
            if (reg_wr && reg_addr == 4'h0) begin
                mode_r <= reg_wdata;
            end
            if (reg_wr && reg_addr == 4'h1) begin
                dflt_r[0] <= reg_wdata == 16'h0007;
            end
            if (reg_wr && reg_addr == 4'h2) begin
                dflt_r[1] <= reg_wdata == 16'h0000;
            end
            if (reg_wr && reg_addr == 4'h3) begin
                dflt_r[2] <= reg_wdata == 16'h0000;
            end
        end
    end
    property p_gate; (mode_r != 16'h0002) [*2] |-> !amp_enable && jog_dir == MJC_DIR_STOP;
    endproperty
    a_gate: assert property (p_gate) else $error("pin command acted outside fixed mode");
    property p_needs; jog_dir != MJC_DIR_STOP |-> amp_enable && !quick_stop && !auto_mode;
    endproperty
    a_needs: assert property (p_needs) else $error("motor moving unpermitted");
    property p_cw; calm && jog_dir == MJC_DIR_CW |-> $past(pin_jog_clockwise
        && !pin_jog_anticlockwise && pin_positive_limit_switch, 3); endproperty
    a_cw: assert property (p_cw) else $error("clockwise move without its cause");
    property p_acw; calm && jog_dir == MJC_DIR_ACW |-> $past(pin_jog_anticlockwise
        && !pin_jog_clockwise && pin_negative_limit_switch, 3); endproperty
    a_acw: assert property (p_acw) else $error("anticlockwise move without cause");
    property p_qstop; calm |-> quick_stop == !$past(pin_stop, 3); endproperty
    a_qstop: assert property (p_qstop) else $error("quick stop does not follow input");
    property p_amp; calm |-> amp_enable == $past(pin_enable, 3); endproperty
    a_amp: assert property (p_amp) else $error("amplifier does not follow input");
    property p_auto; calm |-> auto_mode == $past(pin_automatic_mode_select, 3); endproperty
    a_auto: assert property (p_auto) else $error("automatic mode does not follow input");
    property p_fast; calm |-> jog_fast == $past(pin_jog_speed_select, 3); endproperty
    a_fast: assert property (p_fast) else $error("speed select does not follow input");
    c_cw: cover property (jog_dir == MJC_DIR_CW);
    c_acw: cover property (jog_dir == MJC_DIR_ACW);
    c_qstop: cover property (calm && quick_stop);
endmodule

bind mjc_manual_jog mjc_jog_checker mjc_jog_checker_i (.clk, .arst_n, .reg_addr, .reg_wdata,
    .reg_wr, .pin_positive_limit_switch, .pin_negative_limit_switch, .pin_stop,
    .pin_jog_clockwise, .pin_jog_anticlockwise, .pin_jog_speed_select, .pin_enable,
    .pin_automatic_mode_select, .jog_dir, .jog_fast, .quick_stop, .amp_enable, .auto_mode);

// ---- verif/mjc_switch_model.sv ----
`timescale 1ns/1ps
// An unwired stop or limit input is tied to +24 V, so with active-low polarity it never blocks motion; others float low.
module mjc_switch_model (
    input  wire logic [7:0] sw_conn,
    input  wire logic [7:0] sw_lvl,
    output logic      [7:0] pin_lv
);
    assign pin_lv = (sw_conn & sw_lvl) | (~sw_conn & 8'h07);
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_count++; \
    $display("unexpected %s exp %h got %h", nm, ex, got); end end
module tb_top;
    import mjc_pkg::*;
    logic        clk, arst_n, reg_wr, reg_rd, jog_fast, quick_stop, amp_enable, auto_mode;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, jog_speed, jog_current;
    logic [7:0]  sw_conn, sw_lvl, pin_lv;
    mjc_dir_t    jog_dir;
    int          err_count, checks_done, cyc;
    // Row: levels {auto, enable, fast, acw, cw, stop, -limit, +limit}, dir, stop, amp, auto, fast.
    logic [13:0] rows [9] = '{{8'h4f, 6'h14}, {8'h77, 6'h25}, {8'h5f, 6'h04}, {8'h4b, 6'h0c},
        {8'h4e, 6'h04}, {8'h56, 6'h24}, {8'h55, 6'h04}, {8'hcf, 6'h06}, {8'h0f, 6'h00}};
    mjc_switch_model mjc_switch_model_i (.sw_conn, .sw_lvl, .pin_lv);
    mjc_manual_jog mjc_manual_jog_i (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .pin_positive_limit_switch(pin_lv[0]), .pin_negative_limit_switch(pin_lv[1]),
        .pin_stop(pin_lv[2]), .pin_jog_clockwise(pin_lv[3]), .pin_jog_anticlockwise(pin_lv[4]),
        .pin_jog_speed_select(pin_lv[5]), .pin_enable(pin_lv[6]),
        .pin_automatic_mode_select(pin_lv[7]), .jog_dir, .jog_fast, .jog_speed, .jog_current,
        .quick_stop, .amp_enable, .auto_mode);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task final_report();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            final_report();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] ex);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK("reg_rdata", ex, reg_rdata)
    endtask
    // Pins pass two synchronising flops and an output flop, so five edges leave margin.
    task automatic lv(input logic [7:0] c, input logic [7:0] l);
        @(posedge clk);
        sw_conn <= c;
        sw_lvl  <= l;
        repeat (5) @(posedge clk);
        #1;
    endtask
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {sw_conn, sw_lvl, arst_n} = {8'hff, 8'h07, 1'b0};
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        wr(4'h0, 16'h0002);
        rd(4'h0, 16'h0002);
        foreach (rows[i]) begin
            lv(8'hff, rows[i][13:6]);
            `CHK("jog_dir", rows[i][5:4], jog_dir)
            `CHK("quick_stop", rows[i][3], quick_stop)
            `CHK("amp_enable", rows[i][2], amp_enable)
            `CHK("auto_mode", rows[i][1], auto_mode)
            `CHK("jog_fast", rows[i][0], jog_fast)
            `CHK("jog_speed", rows[i][0] ? 16'h0258 : 16'h003c, jog_speed)
        end
        for (int m = 0; m < 2; m++) begin
            wr(4'h0, 16'(m));
            lv(8'hff, 8'h4f);
            `CHK("gated", 3'b000, {jog_dir, amp_enable})
        end
        wr(4'h0, 16'h0002);
        lv(8'h00, 8'h00);
        `CHK("unwired", 4'b0000, {jog_dir, quick_stop, amp_enable})
        wr(4'h4, 16'h004f);
        wr(4'h3, 16'h00ff);
        lv(8'hff, 8'h00);
        `CHK("forced", MJC_DIR_CW, jog_dir)
        wr(4'h3, 16'h0000);
        wr(4'h5, 16'h0123);
        wr(4'h7, 16'h0005);
        lv(8'hff, 8'h07);
        `CHK("jog_speed", 16'h0123, jog_speed)
        `CHK("jog_current", 16'h0005, jog_current)
        wr(4'h6, 16'h0456);
        lv(8'hff, 8'h27);
        `CHK("jog_speed", 16'h0456, jog_speed)
        wr(4'h1, 16'h0000);
        lv(8'hff, 8'h4a);
        `CHK("masked", {MJC_DIR_CW, 1'b0}, {jog_dir, quick_stop})
        wr(4'h1, 16'h0007);
        wr(4'h2, 16'h0004);
        lv(8'hff, 8'h4b);
        `CHK("polarity", {MJC_DIR_CW, 1'b0}, {jog_dir, quick_stop})
        rd(4'h8, 16'h004b);
        rd(4'h9, 16'h0051);
        rd(4'hf, 16'h0000);
        // A second reset in mid-run must bring the mode, enable, polarity, speed and current registers back to their start values.
        @(posedge clk);
        arst_n <= 1'b0;
        @(posedge clk);
        arst_n <= 1'b1;
        rd(4'h0, 16'h0000);
        rd(4'h1, 16'h0007);
        rd(4'h2, 16'h0000);
        rd(4'h5, 16'h003c);
        rd(4'h6, 16'h0258);
        rd(4'h7, 16'h0009);
        final_report();
    end
endmodule
